// *** testbench.sv ***
// bench for the transfer group
`timescale 1ns/100ps
module testbench
	import xfer_pkg::*;
;
	logic sys_clk_i = 0, rst_n_i = 0, instr_valid_i = 0, skipped_i = 0;
	logic [9:0] opcode_i = 10'h000;
	logic [2:0] stack_ptr_i = 3'h5, tblptr_o;
	logic [3:0] mem_rdata_i = 4'h0, acc_o, aux_o, mem_wdata_o;
	logic [7:0] pair_o;
	logic mem_we_o, skip_next_o;
	mem_pointer_t mem_pointer_o;
	int n_errors = 0, checks = 0;
	xfer_core u_dut (.*);
	initial forever #50 sys_clk_i = ~sys_clk_i;
	initial begin
		#20000 n_errors++;
		close_out;
	end
	task ck(input logic [19:0] s, e);
		checks++;
		if (s !== e) begin
			n_errors++;
			$display("CHECK FAILED %0t %h %h", $time, s, e);
		end
	endtask
	task ex(input logic [9:0] op, input logic [3:0] rd = 4'h0, input logic sk = 1'b0);
		opcode_i = op;
		mem_rdata_i = rd;
		skipped_i = sk;
		@(posedge sys_clk_i) #1;
	endtask
	task t_regs;
		ex(10'h3A5);
		ex(10'h2C0, 4'h9);
		ex(10'h00E);
		ex(10'h2C0, 4'h3);
		ex(10'h01A);
		ck(pair_o, 8'h93);
		ex(10'h01E);
		ck({aux_o, acc_o}, 8'h99);
		ex(10'h01F);
		ck(acc_o, 4'h5);
		ex(10'h2C0, 4'hC);
		ex(10'h00C);
		ck(mem_pointer_o.digit, 4'hC);
		ex(10'h02A);
		ck({aux_o, acc_o}, 8'h93);
		ex(10'h052);
		ck(acc_o, 4'hA);
		ex(10'h2C0, 4'hF);
		ex(10'h029);
		ck(tblptr_o, 3'h7);
		ex(10'h051);
		ck(acc_o, 4'h7);
		ex(10'h2C0, 4'hF);
		ex(10'h050);
		ck(acc_o, 4'h5);
		for (int z = 0; z < 4; z++) begin
			ex({8'h12, 2'(z)});
			ex(10'h053);
			ck({mem_pointer_o.bank, acc_o}, {2'(z), 4'(z)});
		end
	endtask
	task t_ptr;
		ex(10'h3F0);
		ex(10'h345);
		ck(mem_pointer_o, 10'h3F0);
		ex(10'h017);
		ck({skip_next_o, mem_pointer_o.digit}, 5'h1F);
		ex(10'h013);
		ck({skip_next_o, mem_pointer_o.digit}, 5'h10);
		ex(10'h013, 4'h0, 1'b1);
		ck({skip_next_o, mem_pointer_o.digit}, 5'h00);
		ex(10'h013);
		ck({skip_next_o, mem_pointer_o.digit}, 5'h01);
		ex(10'h3CD, 4'h0, 1'b1);
		ex(10'h312);
		ck(mem_pointer_o, 10'h3F1);
		instr_valid_i = 1'b0;
		ex(10'h3AB);
		instr_valid_i = 1'b1;
		ex(10'h3AB);
		ck(mem_pointer_o, 10'h3F1);
	endtask
	task t_mem;
		ex(10'h2C0, 4'h9);
		ex(10'h2D3, 4'h5);
		ck({mem_we_o, mem_wdata_o, acc_o, mem_pointer_o.file}, 13'h195C);
		ex(10'h2C6, 4'hA);
		ck({mem_we_o, acc_o, mem_pointer_o.file}, 9'h0AA);
		ex(10'h2F1, 4'h3);
		ex(10'h2F0, 4'h6);
		ck({skip_next_o, mem_wdata_o, acc_o, mem_pointer_o.file, mem_pointer_o.digit}, 17'h136BF);
		ex(10'h2E2, 4'h8);
		ck({skip_next_o, mem_wdata_o, acc_o, mem_pointer_o.file, mem_pointer_o.digit}, 17'h16890);
		ex(10'h2B6);
		ck({mem_we_o, mem_wdata_o, acc_o, mem_pointer_o.file}, 13'h188F);
	endtask
	task close_out;
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge sys_clk_i);
		#1;
		rst_n_i = 1;
		instr_valid_i = 1;
		t_regs;
		t_ptr;
		t_mem;
		close_out;
	end
endmodule

// *** xfer_core.sv ***
// register transfer and ram address instruction execution
// ------------------------------------------------------------
// Notes on behaviour
// - aux to acc copies all four bits, aux kept
// - acc to aux copies all four bits, acc kept
// - digit pointer copied into acc
// - acc copied into digit pointer
// - pair gets aux high nibble, acc low nibble
// - pair high nibble to aux, low nibble to acc
// - table pointer read puts pointer in acc[2:0], acc[3] zero
// - bank select read puts bank in acc[1:0], upper two zero
// - stack pointer read puts pointer in acc[2:0], acc[3] zero
// - dual load writes x to file pointer, y to digit pointer
// - bank load writes two-bit immediate into bank select
// - digit increment wraps modulo sixteen
// - digit decrement wraps modulo sixteen
// - memory read into acc, then file pointer xor immediate
// - acc and memory swap, file pointer xor immediate
// - swap, xor, and digit decrement
// - acc stored to memory, file pointer xor immediate
// - table pointer takes acc[2:0]
// - consecutive dual loads after the first are skipped
// - increment forms skip next when digit becomes zero
// - decrement forms skip next when digit becomes fifteen
// ------------------------------------------------------------
`timescale 1ns/100ps
`include "xfer_map.svh"
module xfer_core
	import xfer_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic instr_valid_i,
	input wire logic [9:0] opcode_i,
	input wire logic skipped_i,
	input wire logic [2:0] stack_ptr_i,
	input wire logic [3:0] mem_rdata_i,
	output logic [3:0] acc_o,
	output logic [3:0] aux_o,
	output logic [7:0] pair_o,
	output logic [2:0] tblptr_o,
	output mem_pointer_t mem_pointer_o,
	output logic mem_we_o,
	output logic [3:0] mem_wdata_o,
	output logic skip_next_o
);
	xfer_state_t state_reg;
	xfer_state_t state_next;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// digit step, wraps at four bits
	function automatic logic [3:0] step_digit(input logic [3:0] d, input logic up);
		step_digit = up ? 4'(d + 4'h1) : 4'(d - 4'h1);
	endfunction

	// digit value after a step that asks for a skip
	function automatic logic [3:0] wrap_point(input logic up);
		wrap_point = up ? `DIGIT_WRAP_LOW : `DIGIT_WRAP_HIGH;
	endfunction

	// word that changes registers this cycle
	function automatic logic word_taken(input logic valid, input logic skipped);
		word_taken = valid && !skipped;
	endfunction

	// ------------------------------------------------------------
	// opcode decode, single forms
	// ------------------------------------------------------------
	// dual pointer load
	function automatic logic is_dual_load(input logic [9:0] op);
		is_dual_load = op[9:8] == `OPH_LOAD_FILE_DIGIT;
	endfunction

	// bank load, immediate in the two low bits
	function automatic logic is_bank_load(input logic [9:0] op);
		is_bank_load = op[9:2] == `OPH_LOAD_BANK;
	endfunction

	// memory nibble into acc
	function automatic logic is_mem_read(input logic [9:0] op);
		is_mem_read = op[9:4] == `OPH_ACC_FROM_MEM;
	endfunction

	// acc into memory nibble
	function automatic logic is_mem_write(input logic [9:0] op);
		is_mem_write = op[9:4] == `OPH_MEM_FROM_ACC;
	endfunction

	// plain swap
	function automatic logic is_swap_plain(input logic [9:0] op);
		is_swap_plain = op[9:4] == `OPH_SWAP_MEM;
	endfunction

	// swap with digit increment
	function automatic logic is_swap_inc(input logic [9:0] op);
		is_swap_inc = op[9:4] == `OPH_SWAP_MEM_INC;
	endfunction

	// swap with digit decrement
	function automatic logic is_swap_dec(input logic [9:0] op);
		is_swap_dec = op[9:4] == `OPH_SWAP_MEM_DEC;
	endfunction

	// ------------------------------------------------------------
	// opcode decode, combined forms
	// ------------------------------------------------------------
	// any of the three swaps
	function automatic logic is_swap_any(input logic [9:0] op);
		is_swap_any = is_swap_plain(op) || is_swap_inc(op) || is_swap_dec(op);
	endfunction

	// digit steps up
	function automatic logic is_step_up(input logic [9:0] op);
		is_step_up = op == `OP_INC_DIGIT || is_swap_inc(op);
	endfunction

	// digit steps down
	function automatic logic is_step_down(input logic [9:0] op);
		is_step_down = op == `OP_DEC_DIGIT || is_swap_dec(op);
	endfunction

	// file pointer xor with the immediate
	function automatic logic is_file_xor(input logic [9:0] op);
		is_file_xor = is_mem_read(op) || is_mem_write(op) || is_swap_any(op);
	endfunction

	// acc stored to the addressed nibble
	function automatic logic is_mem_store(input logic [9:0] op);
		is_mem_store = is_mem_write(op) || is_swap_any(op);
	endfunction

	// dual load straight after a dual load is dropped
	function automatic logic is_chained(input xfer_state_t s, input logic [9:0] op);
		is_chained = is_dual_load(op) && s.last_lxy;
	endfunction

	// ------------------------------------------------------------
	// next value, data registers
	// ------------------------------------------------------------
	// accumulator
	function automatic logic [3:0] next_acc(input xfer_state_t s, input logic [9:0] op,
		input logic [2:0] sp, input logic [3:0] rd);
		next_acc = s.acc;
		if (is_mem_read(op) || is_swap_any(op)) begin
			next_acc = rd;
		end else begin
			unique case (op)
				`OP_ACC_FROM_AUX: next_acc = s.aux;
				`OP_ACC_FROM_DIGIT: next_acc = s.digit_ptr;
				`OP_ACC_AUX_FROM_PAIR: next_acc = s.pair[3:0];
				`OP_ACC_FROM_TBLPTR: next_acc = {1'b0, s.tblptr};
				`OP_ACC_FROM_BANK: next_acc = {2'b00, s.bank_sel};
				`OP_ACC_FROM_STACK: next_acc = {1'b0, sp};
				`OP_ACC_FROM_FILE: next_acc = s.file_ptr;
				default: next_acc = s.acc;
			endcase
		end
	endfunction

	// auxiliary register
	function automatic logic [3:0] next_aux(input xfer_state_t s, input logic [9:0] op);
		unique case (op)
			`OP_AUX_FROM_ACC: next_aux = s.acc;
			`OP_ACC_AUX_FROM_PAIR: next_aux = s.pair[7:4];
			default: next_aux = s.aux;
		endcase
	endfunction

	// pair register
	function automatic logic [7:0] next_pair(input xfer_state_t s, input logic [9:0] op);
		next_pair = s.pair;
		if (op == `OP_PAIR_FROM_ACC_AUX) begin
			next_pair = {s.aux, s.acc};
		end
	endfunction

	// write data for the memory strobe
	function automatic logic [3:0] next_wdata(input xfer_state_t s, input logic [9:0] op);
		next_wdata = s.mem_wdata;
		if (is_mem_store(op)) begin
			next_wdata = s.acc;
		end
	endfunction

	// ------------------------------------------------------------
	// next value, pointers
	// ------------------------------------------------------------
	// table pointer
	function automatic logic [2:0] next_tblptr(input xfer_state_t s, input logic [9:0] op);
		next_tblptr = s.tblptr;
		if (op == `OP_TBLPTR_FROM_ACC) begin
			next_tblptr = s.acc[2:0];
		end
	endfunction

	// bank select
	function automatic logic [1:0] next_bank(input xfer_state_t s, input logic [9:0] op);
		next_bank = s.bank_sel;
		if (is_bank_load(op)) begin
			next_bank = op[1:0];
		end
	endfunction

	// file pointer
	function automatic logic [3:0] next_file(input xfer_state_t s, input logic [9:0] op);
		next_file = s.file_ptr;
		if (is_chained(s, op)) begin
			next_file = s.file_ptr;
		end else if (is_dual_load(op)) begin
			next_file = op[7:4];
		end else if (is_file_xor(op)) begin
			next_file = s.file_ptr ^ op[3:0];
		end
	endfunction

	// digit pointer
	function automatic logic [3:0] next_digit(input xfer_state_t s, input logic [9:0] op);
		next_digit = s.digit_ptr;
		if (is_chained(s, op)) begin
			next_digit = s.digit_ptr;
		end else if (is_dual_load(op)) begin
			next_digit = op[3:0];
		end else if (is_step_up(op)) begin
			next_digit = step_digit(s.digit_ptr, 1'b1);
		end else if (is_step_down(op)) begin
			next_digit = step_digit(s.digit_ptr, 1'b0);
		end else if (op == `OP_DIGIT_FROM_ACC) begin
			next_digit = s.acc;
		end
	endfunction

	// ------------------------------------------------------------
	// next value, skip request
	// ------------------------------------------------------------
	// skip when the step lands on the wrap point
	function automatic logic next_skip(input xfer_state_t s, input logic [9:0] op);
		next_skip = 1'b0;
		if (is_step_up(op)) begin
			next_skip = step_digit(s.digit_ptr, 1'b1) == wrap_point(1'b1);
		end else if (is_step_down(op)) begin
			next_skip = step_digit(s.digit_ptr, 1'b0) == wrap_point(1'b0);
		end
	endfunction

	// ------------------------------------------------------------
	// execute, one instruction per cycle
	// ------------------------------------------------------------
	always_comb begin
		logic take;
		take = word_taken(instr_valid_i, skipped_i);
		state_next = state_reg;
		state_next.mem_we = 1'b0;
		state_next.skip_next = 1'b0;

		// chain tracking sees skipped words too
		if (instr_valid_i) begin
			state_next.last_lxy = is_dual_load(opcode_i);
		end
		// only taken words update data and pointer registers
		if (take) begin
			// data registers
			state_next.acc = next_acc(state_reg, opcode_i, stack_ptr_i, mem_rdata_i);
			state_next.aux = next_aux(state_reg, opcode_i);
			state_next.pair = next_pair(state_reg, opcode_i);
			state_next.mem_wdata = next_wdata(state_reg, opcode_i);
			state_next.mem_we = is_mem_store(opcode_i);

			// pointers
			state_next.tblptr = next_tblptr(state_reg, opcode_i);
			state_next.bank_sel = next_bank(state_reg, opcode_i);
			state_next.file_ptr = next_file(state_reg, opcode_i);
			state_next.digit_ptr = next_digit(state_reg, opcode_i);

			// skip request
			state_next.skip_next = next_skip(state_reg, opcode_i);
		end
	end

	// ------------------------------------------------------------
	// state register, single cycle per instruction
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign acc_o = state_reg.acc;
	assign aux_o = state_reg.aux;
	assign pair_o = state_reg.pair;
	assign tblptr_o = state_reg.tblptr;
	assign mem_pointer_o = '{bank: state_reg.bank_sel, file: state_reg.file_ptr, digit: state_reg.digit_ptr};
	assign mem_we_o = state_reg.mem_we;
	assign mem_wdata_o = state_reg.mem_wdata;
	assign skip_next_o = state_reg.skip_next;
endmodule

// *** xfer_core_checker.sv ***
// assertions for the transfer group
`timescale 1ns/100ps
`include "xfer_map.svh"
module xfer_core_checker
	import xfer_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic instr_valid_i,
	input wire logic skipped_i,
	input wire logic [9:0] opcode_i,
	input wire logic [3:0] mem_rdata_i,
	input wire logic [3:0] acc_o,
	input wire logic [3:0] aux_o,
	input wire logic [7:0] pair_o,
	input wire logic [2:0] tblptr_o,
	input wire mem_pointer_t mem_pointer_o,
	input wire logic mem_we_o,
	input wire logic [3:0] mem_wdata_o,
	input wire logic skip_next_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	wire logic tk = instr_valid_i && !skipped_i;
	wire logic [3:0] imm = opcode_i[3:0];
	wire logic [3:0] dg = mem_pointer_o.digit;
	sequence s_dual; tk && opcode_i[9:8] == `OPH_LOAD_FILE_DIGIT; endsequence
	sequence s_inc; tk && (opcode_i == `OP_INC_DIGIT || opcode_i[9:4] == `OPH_SWAP_MEM_INC); endsequence
	sequence s_dec; tk && (opcode_i == `OP_DEC_DIGIT || opcode_i[9:4] == `OPH_SWAP_MEM_DEC); endsequence
	a_acc_from_aux: assert property (tk && opcode_i == `OP_ACC_FROM_AUX
		|=> acc_o == $past(aux_o) && $stable(aux_o)) else $error("acc from aux");
	a_pair_load: assert property (tk && opcode_i == `OP_PAIR_FROM_ACC_AUX
		|=> pair_o == {$past(aux_o), $past(acc_o)}) else $error("pair load");
	a_tbl_read: assert property (tk && opcode_i == `OP_ACC_FROM_TBLPTR
		|=> acc_o == {1'b0, $past(tblptr_o)}) else $error("tblptr read");
	a_inc_skip: assert property (s_inc
		|=> dg == $past(dg) + 4'h1 && skip_next_o == (dg == 4'h0)) else $error("digit inc");
	a_dec_skip: assert property (s_dec
		|=> dg == $past(dg) - 4'h1 && skip_next_o == (dg == 4'hF)) else $error("digit dec");
	a_swap_mem: assert property (tk && opcode_i[9:4] == `OPH_SWAP_MEM
		|=> acc_o == $past(mem_rdata_i) && mem_we_o && mem_wdata_o == $past(acc_o)) else $error("swap");
	a_mem_write: assert property (tk && opcode_i[9:4] == `OPH_MEM_FROM_ACC
		|=> mem_we_o && mem_pointer_o.file == ($past(mem_pointer_o.file) ^ $past(imm))) else $error("mem write");
	a_dual_chain: assert property (s_dual ##1 s_dual
		|=> $stable(mem_pointer_o)) else $error("dual chain");
endmodule
bind xfer_core xfer_core_checker u_chk (.*);

// *** xfer_map.svh ***
// opcode encodings and field positions for the transfer and ram address group
`ifndef XFER_MAP_SVH
`define XFER_MAP_SVH
`define OP_ACC_FROM_AUX 10'h01E
`define OP_AUX_FROM_ACC 10'h00E
`define OP_ACC_FROM_DIGIT 10'h01F
`define OP_DIGIT_FROM_ACC 10'h00C
`define OP_PAIR_FROM_ACC_AUX 10'h01A
`define OP_ACC_AUX_FROM_PAIR 10'h02A
`define OP_TBLPTR_FROM_ACC 10'h029
`define OP_ACC_FROM_TBLPTR 10'h051
`define OP_ACC_FROM_BANK 10'h053
`define OP_ACC_FROM_FILE 10'h052
`define OP_ACC_FROM_STACK 10'h050
`define OP_INC_DIGIT 10'h013
`define OP_DEC_DIGIT 10'h017
`define OPH_LOAD_BANK 8'h12
`define OPH_LOAD_FILE_DIGIT 2'h3
`define OPH_ACC_FROM_MEM 6'h2C
`define OPH_SWAP_MEM 6'h2D
`define OPH_SWAP_MEM_INC 6'h2E
`define OPH_SWAP_MEM_DEC 6'h2F
`define OPH_MEM_FROM_ACC 6'h2B
`define DIGIT_WRAP_LOW 4'h0
`define DIGIT_WRAP_HIGH 4'hF
`endif

// *** xfer_pkg.sv ***
// types for the transfer and ram address group
package xfer_pkg;
	typedef struct packed {
		logic [3:0] acc;
		logic [3:0] aux;
		logic [7:0] pair;
		logic [3:0] file_ptr;
		logic [3:0] digit_ptr;
		logic [1:0] bank_sel;
		logic [2:0] tblptr;
		logic last_lxy;
		logic skip_next;
		logic mem_we;
		logic [3:0] mem_wdata;
	} xfer_state_t;
	typedef struct packed {
		logic [1:0] bank;
		logic [3:0] file;
		logic [3:0] digit;
	} mem_pointer_t;
endpackage
